// ### src/rivs_regs.svh
`ifndef RIVS_REGS_SVH
`define RIVS_REGS_SVH
`define RIVS_RESET_APP_ADDR 14'h0000
`define RIVS_TABLE_APP_BASE 14'h0002
`define RIVS_TABLE_BOOT_OFS 14'h0002
`define RIVS_SLOT_WORDS 14'h0002
`define RIVS_FIRST_IRQ_VEC 5'h02
`define RIVS_LAST_VEC 5'h1a
`define RIVS_LAST_SRC_BIT 5'h18
`define RIVS_LAST_VEC_ADDR 14'h0032
`define RIVS_FUSE_UNPROG 1'b1
`endif

// ### src/rivs_pkg.sv
package rivs_pkg;
  typedef logic [13:0] rivs_addr_t;
  typedef logic [4:0] rivs_vec_t;
endpackage

// ### src/rivs_top.sv
`timescale 1ns/1ps
`include "rivs_regs.svh"
module rivs_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic BOOT_RESET_SELECT_FUSE,
  input wire logic VECTOR_TABLE_SELECT_BIT,
  input wire rivs_pkg::rivs_addr_t BOOT_RESET_ADDR,
  input wire logic [25:0] IRQ_REQ,
  input wire logic IRQ_TAKE,
  output logic IRQ_PENDING,
  output rivs_pkg::rivs_vec_t VEC_NUM,
  output rivs_pkg::rivs_addr_t RESET_VECTOR,
  output rivs_pkg::rivs_addr_t VECTOR_ADDR
);
  import rivs_pkg::*;

  // --------------------------------------------------------------
  // Address arithmetic
  // --------------------------------------------------------------
  // Every slot is two words wide, so the offset is the vector number minus two, doubled.
  function automatic rivs_addr_t slot_addr(input rivs_addr_t base, input rivs_vec_t n);
    rivs_vec_t rel;
    rivs_addr_t idx;
    rel = n - `RIVS_FIRST_IRQ_VEC;
    idx = {9'h000, rel};
    slot_addr = 14'(base + idx * `RIVS_SLOT_WORDS);
  endfunction

  // The fuse reads one when unprogrammed; only a programmed fuse moves the reset entry.
  function automatic rivs_addr_t reset_addr(input logic fuse, input rivs_addr_t boot);
    if (fuse == `RIVS_FUSE_UNPROG) begin
      reset_addr = `RIVS_RESET_APP_ADDR;
    end else begin
      reset_addr = boot;
    end
  endfunction

  // The table start ignores the fuse, so the two choices mix freely.
  function automatic rivs_addr_t table_start(input logic vsel, input rivs_addr_t boot);
    if (vsel) begin
      table_start = 14'(boot + `RIVS_TABLE_BOOT_OFS);
    end else begin
      table_start = `RIVS_TABLE_APP_BASE;
    end
  endfunction

  // --------------------------------------------------------------
  // Priority
  // --------------------------------------------------------------
  // Lowest vector number wins, matching the fixed hardware priority order.
  function automatic rivs_vec_t winner(input logic [25:0] req);
    winner = `RIVS_FIRST_IRQ_VEC;
    for (int i = `RIVS_LAST_SRC_BIT; i >= 0; i--) begin
      if (req[i]) begin
        winner = 5'(i + `RIVS_FIRST_IRQ_VEC);
      end
    end
  endfunction

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  // Straps are sampled each clock; changing them mid-run only moves the next fetch.
  rivs_addr_t reset_d;
  rivs_addr_t reset_q;
  rivs_addr_t vaddr_d;
  rivs_addr_t vaddr_q;
  rivs_addr_t tbase;
  rivs_vec_t vnum_d;
  rivs_vec_t vnum_q;
  logic pend_d;
  logic pend_q;

  always_comb begin
    reset_d = reset_addr(BOOT_RESET_SELECT_FUSE, BOOT_RESET_ADDR);
    tbase = table_start(VECTOR_TABLE_SELECT_BIT, BOOT_RESET_ADDR);
    vnum_d = winner(IRQ_REQ);
    vaddr_d = slot_addr(tbase, vnum_d);
    // The spare source has no slot, so it never raises a request.
    pend_d = |IRQ_REQ[`RIVS_LAST_SRC_BIT:0];
    // A take wins for one update, so a taken request is not offered twice in a row.
    if (IRQ_TAKE) begin
      pend_d = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      reset_q <= `RIVS_RESET_APP_ADDR;
      vaddr_q <= `RIVS_TABLE_APP_BASE;
      vnum_q <= `RIVS_FIRST_IRQ_VEC;
      pend_q <= 1'b0;
    end else begin
      reset_q <= reset_d;
      vaddr_q <= vaddr_d;
      vnum_q <= vnum_d;
      pend_q <= pend_d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Every output comes straight from a flop, so the fetch logic never sees a glitch.
  assign RESET_VECTOR = reset_q;
  assign VECTOR_ADDR = vaddr_q;
  assign VEC_NUM = vnum_q;
  assign IRQ_PENDING = pend_q;

  // --------------------------------------------------------------
  // Sequences
  // --------------------------------------------------------------
  sequence s_taken;
    IRQ_PENDING && IRQ_TAKE;
  endsequence

  sequence s_take_then_free;
    IRQ_TAKE ##1 (!IRQ_TAKE && (|IRQ_REQ[`RIVS_LAST_SRC_BIT:0]));
  endsequence

  sequence s_first_src_seen;
    $past(IRQ_REQ[0]);
  endsequence

  sequence s_app_table_seen;
    !$past(VECTOR_TABLE_SELECT_BIT);
  endsequence

  sequence s_boot_table_seen;
    $past(VECTOR_TABLE_SELECT_BIT);
  endsequence

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  a_reset_vec_app: assert property (@(posedge CLK) disable iff (!NRST)
    $past(BOOT_RESET_SELECT_FUSE) |-> RESET_VECTOR == `RIVS_RESET_APP_ADDR)
    else $error("reset vector not zero");

  a_reset_vec_boot: assert property (@(posedge CLK) disable iff (!NRST)
    !$past(BOOT_RESET_SELECT_FUSE) |-> RESET_VECTOR == $past(BOOT_RESET_ADDR))
    else $error("boot reset bad");

  a_table_app_start: assert property (@(posedge CLK) disable iff (!NRST)
    (s_first_src_seen and s_app_table_seen) |-> VECTOR_ADDR == `RIVS_TABLE_APP_BASE)
    else $error("app table");

  a_table_boot_start: assert property (@(posedge CLK) disable iff (!NRST)
    (s_first_src_seen and s_boot_table_seen) |-> VECTOR_ADDR == 14'($past(BOOT_RESET_ADDR) + `RIVS_TABLE_BOOT_OFS))
    else $error("boot table");

  a_slot_spacing: assert property (@(posedge CLK) disable iff (!NRST)
    s_app_table_seen |-> VECTOR_ADDR == 14'({8'h00, VEC_NUM, 1'b0} - `RIVS_SLOT_WORDS))
    else $error("slot spacing");

  a_last_vector: assert property (@(posedge CLK) disable iff (!NRST)
    ($past(IRQ_REQ) == 26'h1000000 && !$past(VECTOR_TABLE_SELECT_BIT)) |-> VECTOR_ADDR == `RIVS_LAST_VEC_ADDR)
    else $error("last vector");

  a_vec_range: assert property (@(posedge CLK) disable iff (!NRST)
    VEC_NUM >= `RIVS_FIRST_IRQ_VEC && VEC_NUM <= `RIVS_LAST_VEC)
    else $error("vector out of range");

  a_mixed_place: assert property (@(posedge CLK) disable iff (!NRST)
    ($past(BOOT_RESET_SELECT_FUSE) && $past(VECTOR_TABLE_SELECT_BIT) && $past(IRQ_REQ[0]))
    |-> RESET_VECTOR == `RIVS_RESET_APP_ADDR
    && VECTOR_ADDR == 14'($past(BOOT_RESET_ADDR) + `RIVS_TABLE_BOOT_OFS))
    else $error("mixed");

  a_first_vec: assert property (@(posedge CLK) disable iff (!NRST)
    s_first_src_seen |-> VEC_NUM == `RIVS_FIRST_IRQ_VEC)
    else $error("priority");

  a_boot_slot: assert property (@(posedge CLK) disable iff (!NRST)
    s_boot_table_seen |-> VECTOR_ADDR == 14'($past(BOOT_RESET_ADDR) + {8'h00, VEC_NUM, 1'b0} - `RIVS_SLOT_WORDS))
    else $error("boot slot");

  a_fetch_even: assert property (@(posedge CLK) disable iff (!NRST)
    s_app_table_seen |-> !VECTOR_ADDR[0])
    else $error("odd vector address");

  a_priority_pair: assert property (@(posedge CLK) disable iff (!NRST)
    ($past(IRQ_REQ[2:1]) == 2'b11 && !$past(IRQ_REQ[0])) |-> VEC_NUM == 5'(`RIVS_FIRST_IRQ_VEC + 5'h01))
    else $error("priority pair");

  a_pend_idle: assert property (@(posedge CLK) disable iff (!NRST)
    $past(IRQ_REQ[`RIVS_LAST_SRC_BIT:0]) == 25'h0000000 |-> !IRQ_PENDING)
    else $error("pending without request");

  a_spare_ignored: assert property (@(posedge CLK) disable iff (!NRST)
    $past(IRQ_REQ) == 26'h2000000 |-> !IRQ_PENDING && VEC_NUM == `RIVS_FIRST_IRQ_VEC)
    else $error("spare source seen");

  a_take_drops: assert property (@(posedge CLK) disable iff (!NRST)
    s_taken |=> !IRQ_PENDING)
    else $error("take did not drop pending");

  a_take_frees: assert property (@(posedge CLK) disable iff (!NRST)
    s_take_then_free |=> IRQ_PENDING)
    else $error("pending not raised again");

  a_reset_values: assert property (@(posedge CLK)
    (!NRST ##1 !NRST) |-> RESET_VECTOR == `RIVS_RESET_APP_ADDR && VECTOR_ADDR == `RIVS_TABLE_APP_BASE
    && VEC_NUM == `RIVS_FIRST_IRQ_VEC && !IRQ_PENDING)
    else $error("outputs not at reset values");
endmodule

// ### sim/rivs_core_model.sv
`timescale 1ns/1ps
module rivs_core_model (
  input wire logic clk,
  input wire logic en,
  input wire logic pend,
  output logic take
);
  // The core takes a pending request at once, so the next update must drop it.
  initial take = 1'b0;
  always @(negedge clk) begin
    take <= en & pend;
  end
endmodule

// ### sim/reset_interrupt_vector_select_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, a); end end
module reset_interrupt_vector_select_tb;
  import rivs_pkg::*;
  logic clk = 0, nrst = 0, fuse = 1, sel = 0, en = 0, take, pend;
  rivs_addr_t boot = 14'h3c00, rv, va;
  logic [25:0] req = '0;
  rivs_vec_t vn;
  int n_mismatch = 0, n_compared = 0;
  rivs_top rivs_top_inst (.CLK(clk), .NRST(nrst), .BOOT_RESET_SELECT_FUSE(fuse), .VECTOR_TABLE_SELECT_BIT(sel),
    .BOOT_RESET_ADDR(boot), .IRQ_REQ(req), .IRQ_TAKE(take), .IRQ_PENDING(pend), .VEC_NUM(vn),
    .RESET_VECTOR(rv), .VECTOR_ADDR(va));
  rivs_core_model rivs_core_model_inst (.clk(clk), .en(en), .pend(pend), .take(take));
  initial forever #5 clk = ~clk;
  task automatic placement();
    req = 26'h1;
    for (int i = 0; i < 4; i++) begin
      fuse = i[1];
      sel = i[0];
      @(negedge clk);
      `CHK("reset vector", fuse ? 14'h0000 : boot, rv)
      `CHK("table start", sel ? boot + 14'h0002 : 14'h0002, va)
      `CHK("first vector", 5'h02, vn)
    end
  endtask
  task automatic vectors();
    sel = 1'b0;
    for (int n = 2; n <= 26; n++) begin
      req = 26'h1 << (n - 2);
      @(negedge clk);
      `CHK("vector number", n[4:0], vn)
      `CHK("vector address", 14'(2 * n - 2), va)
      `CHK("pending", 1'b1, pend)
    end
    req = 26'h0000006;
    @(negedge clk);
    `CHK("priority number", 5'h03, vn)
    `CHK("priority address", 14'h0004, va)
    req = 26'h2000000;
    @(negedge clk);
    `CHK("unused source", 1'b0, pend)
  endtask
  task automatic take_request();
    en = 1'b1;
    req = 26'h1;
    repeat (2) @(negedge clk);
    `CHK("taken", 1'b0, pend)
    @(negedge clk);
    `CHK("pending again", 1'b1, pend)
    en = 1'b0;
    req = '0;
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    placement();
    vectors();
    take_request();
    give_verdict();
  end
endmodule
